// >>> logic/dfb_dma_sched.sv
// Behaviour
// RULE_01: Pending remote transfers yield to local DMA while a frame moves.
// RULE_02: After local work the remote transfer re-requests and resumes.
// RULE_03: FIFO need during a remote tenure keeps request and appends burst.
// RULE_04: Going from local to remote drops the request for a cycle.
// RULE_05: A 16-byte FIFO with programmable threshold buffers the data.
// RULE_06: Reaching the threshold starts a local burst to memory.
// RULE_07: The arbiter must grant fast enough to avoid under or overrun.
// RULE_08: Transmit enable stays active across a FIFO underrun.
// RULE_09: The 8-byte address field stays in the FIFO at frame start.
// RULE_10: First receive request comes 7.8 us after start of frame.
// RULE_11: First receive burst waits for 8 bytes whatever the threshold.
// RULE_12: Carrier loss drains the FIFO, then writes the status header.
// RULE_13: The request stays asserted through the whole end-of-frame work.
// RULE_14: A frame ending mid-burst finishes burst, flush and prep together.
// RULE_15: The 4-byte or 2-word header is last, then the request falls.
// RULE_16: Byte mode requests at n+1 bytes, word mode at n+2.
// RULE_17: The thirteenth byte written flags a FIFO overrun.
// RULE_18: Each local tenure moves exactly the burst length, then releases; the code runs an end-of-frame tenure on into flush and header.
// RULE_19: Remote transfers arbitrate once per byte or word.
`timescale 1ns/1ps
module dfb_dma_sched #(
    parameter int FIRST_CYC = dfb_pkg::FIRST_REQ_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       word_mode,
    input  wire logic [1:0] thresh_sel,
    input  wire logic       start_of_frame,
    input  wire logic       carrier_sense,
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_data,
    input  wire logic       tx_active,
    input  wire logic       tx_take,
    input  wire logic       bus_grant,
    input  wire logic [7:0] mem_rdata,
    input  wire logic       remote_pending,
    output logic            bus_request_out,
    output logic            mem_write,
    output logic            mem_read,
    output logic            mem_header,
    output logic [7:0]      mem_wdata,
    output logic [7:0]      tx_data,
    output logic            line_transmit_enable,
    output logic            remote_step,
    output logic            fifo_overrun,
    output logic            fifo_underrun
);
    localparam int PW = dfb_pkg::PTR_W;
    localparam int CW = dfb_pkg::CNT_W;
    localparam int FW = dfb_pkg::FIRST_CNT_W;

    dfb_pkg::dfb_state_type state_reg, state_next;
    logic [CW-1:0] count_reg, count_next;
    logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [CW-1:0] beat_reg, beat_next;
    logic [2:0]    hdr_reg, hdr_next;
    logic [FW-1:0] first_cnt_reg, first_cnt_next;
    logic          rx_mode_reg, rx_mode_next;
    logic          first_reg, first_next;
    logic          eof_reg, eof_next;
    logic          carrier_d_reg;
    logic          req_reg, req_next;
    logic          wr_reg, wr_next, rd_reg, rd_next, hdr_w_reg, hdr_w_next;
    logic [7:0]    wdata_reg, wdata_next, txd_reg, txd_next;
    logic          txe_reg, rstep_reg, rstep_next;
    logic          ovr_reg, ovr_next, unr_reg, unr_next;
    logic          push, pop, pop_rx, pop_tx;
    logic [CW-1:0] thr, rx_lvl, lvl;
    logic          need_rx, need_tx, local_need, burst_last;
    logic [2:0]    hdr_last;

    dfb_fifo_if #(.AW(PW), .DW(8)) fif ();

    dfb_fifo_mem #(.AW(PW), .DW(8)) u_mem (
        .clk   (clk),
        .rst_n (rst_n),
        .port  (fif.store)
    );

    // Burst length and threshold from the programmed setting.
    always_comb begin
        case (thresh_sel)
            2'b00:   thr = dfb_pkg::THR_2;
            2'b01:   thr = dfb_pkg::THR_4;
            2'b10:   thr = dfb_pkg::THR_8;
            default: thr = dfb_pkg::THR_12;
        endcase
    end

    always_comb begin
        rx_lvl = thr + (word_mode ? dfb_pkg::WORD_MODE_ADD
                                  : dfb_pkg::BYTE_MODE_ADD); // [RULE_16]
        lvl = rx_lvl;
        if (first_reg && rx_lvl < dfb_pkg::FIRST_RX_BYTES) begin
            lvl = dfb_pkg::FIRST_RX_BYTES; // [RULE_09] [RULE_11]
        end
        need_rx = rx_mode_reg && !eof_reg && count_reg >= lvl
                  && (!first_reg || first_cnt_reg == '0); // [RULE_10]
        need_tx = !rx_mode_reg && tx_active
                  && (dfb_pkg::FIFO_FULL - count_reg) >= thr; // [RULE_06]
        local_need = need_rx || need_tx || eof_reg; // [RULE_06]
        burst_last = beat_reg == thr - 5'h01; // [RULE_18]
        hdr_last = (word_mode ? dfb_pkg::HDR_WORDS : dfb_pkg::HDR_BYTES)
                   - 3'h1;
    end

    // FIFO moves: network side and memory side.
    always_comb begin
        pop_rx = rx_mode_reg && count_reg != '0
                 && (state_reg == dfb_pkg::ST_LOCAL
                     || state_reg == dfb_pkg::ST_FLUSH);
        pop_tx = !rx_mode_reg && tx_take && count_reg != '0;
        pop = pop_rx || pop_tx;
        push = (rx_mode_reg && carrier_sense && rx_valid && !eof_reg
                && count_reg != dfb_pkg::FIFO_FULL)
               || (!rx_mode_reg && rd_reg); // [RULE_05]
        count_next = count_reg + CW'(push) - CW'(pop);
        wr_ptr_next = wr_ptr_reg + PW'(push);
        rd_ptr_next = rd_ptr_reg + PW'(pop);
    end

    assign fif.wr_en   = push;
    assign fif.wr_addr = wr_ptr_reg;
    assign fif.wr_data = rx_mode_reg ? rx_data : mem_rdata;
    assign fif.rd_addr = rd_ptr_next;

    always_comb begin
        state_next = state_reg;
        req_next = 1'b0;
        beat_next = beat_reg;
        hdr_next = hdr_reg;
        rd_next = 1'b0;
        hdr_w_next = 1'b0;
        rstep_next = 1'b0;
        rx_mode_next = rx_mode_reg;
        first_next = first_reg;
        first_cnt_next = first_cnt_reg;
        eof_next = eof_reg;
        wr_next = pop_rx;
        wdata_next = pop_rx ? fif.rd_data : wdata_reg;
        txd_next = pop_tx ? fif.rd_data : txd_reg;
        ovr_next = ovr_reg;
        unr_next = unr_reg;
        if (first_cnt_reg != '0) begin
            first_cnt_next = first_cnt_reg - FW'(1);
        end
        if (start_of_frame) begin
            rx_mode_next = 1'b1;
            first_next = 1'b1;
            first_cnt_next = FW'(FIRST_CYC); // [RULE_10]
            ovr_next = 1'b0;
        end
        if (rx_mode_reg && carrier_d_reg && !carrier_sense) begin
            eof_next = 1'b1; // [RULE_12]
        end
        if (push && rx_mode_reg && count_reg == dfb_pkg::OVERRUN_LEVEL) begin
            ovr_next = 1'b1; // [RULE_17]
        end
        if (!tx_active) begin
            unr_next = 1'b0;
        end
        if (!rx_mode_reg && tx_active && tx_take && count_reg == '0) begin
            unr_next = 1'b1;
        end
        case (state_reg)
            dfb_pkg::ST_IDLE: begin
                if (local_need) begin
                    state_next = dfb_pkg::ST_REQ_LOCAL; // [RULE_01]
                    req_next = 1'b1;
                end else if (remote_pending) begin
                    state_next = dfb_pkg::ST_REQ_REMOTE; // [RULE_02]
                    req_next = 1'b1;
                end
            end
            dfb_pkg::ST_REQ_LOCAL: begin
                req_next = 1'b1;
                beat_next = '0;
                if (bus_grant) begin
                    first_next = 1'b0;
                    state_next = (eof_reg && !need_rx) ? dfb_pkg::ST_FLUSH
                                                       : dfb_pkg::ST_LOCAL;
                    rd_next = !rx_mode_reg && !eof_reg;
                end
            end
            dfb_pkg::ST_LOCAL: begin
                req_next = 1'b1;
                beat_next = beat_reg + CW'(1);
                if (!bus_grant) begin
                    state_next = dfb_pkg::ST_IDLE;
                    req_next = 1'b0;
                end else if (burst_last) begin
                    if (eof_next) begin
                        state_next = dfb_pkg::ST_FLUSH; // [RULE_14]
                    end else begin
                        state_next = dfb_pkg::ST_IDLE; // [RULE_04] [RULE_18]
                        req_next = 1'b0;
                    end
                end else begin
                    rd_next = !rx_mode_reg;
                end
            end
            dfb_pkg::ST_FLUSH: begin
                req_next = 1'b1; // [RULE_13]
                hdr_next = '0;
                if (count_next == '0) begin
                    state_next = dfb_pkg::ST_PREP; // [RULE_12]
                end
            end
            dfb_pkg::ST_PREP: begin
                req_next = 1'b1; // [RULE_13]
                state_next = dfb_pkg::ST_HEADER;
            end
            dfb_pkg::ST_HEADER: begin
                wr_next = 1'b1;
                hdr_w_next = 1'b1;
                wdata_next = {6'h00, ovr_reg, 1'b1};
                hdr_next = hdr_reg + 3'h1;
                req_next = 1'b1;
                if (hdr_reg == hdr_last) begin
                    state_next = dfb_pkg::ST_IDLE; // [RULE_15]
                    req_next = 1'b0;
                    rx_mode_next = start_of_frame;
                    eof_next = 1'b0;
                end
            end
            dfb_pkg::ST_REQ_REMOTE: begin
                req_next = 1'b1;
                if (bus_grant) begin
                    state_next = dfb_pkg::ST_REMOTE;
                    rstep_next = 1'b1; // [RULE_19]
                end
            end
            dfb_pkg::ST_REMOTE: begin
                beat_next = '0;
                if (local_need) begin
                    state_next = dfb_pkg::ST_LOCAL; // [RULE_03]
                    req_next = 1'b1;
                    first_next = 1'b0;
                    rd_next = !rx_mode_reg && !eof_reg;
                end else begin
                    state_next = dfb_pkg::ST_IDLE; // [RULE_19]
                end
            end
            default: begin
                state_next = dfb_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= dfb_pkg::ST_IDLE;
            count_reg <= '0;
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            beat_reg <= '0;
            hdr_reg <= '0;
            first_cnt_reg <= '0;
            rx_mode_reg <= 1'b0;
            first_reg <= 1'b0;
            eof_reg <= 1'b0;
            carrier_d_reg <= 1'b0;
            req_reg <= 1'b0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            hdr_w_reg <= 1'b0;
            wdata_reg <= 8'h00;
            txd_reg <= 8'h00;
            txe_reg <= 1'b0;
            rstep_reg <= 1'b0;
            ovr_reg <= 1'b0;
            unr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            beat_reg <= beat_next;
            hdr_reg <= hdr_next;
            first_cnt_reg <= first_cnt_next;
            rx_mode_reg <= rx_mode_next;
            first_reg <= first_next;
            eof_reg <= eof_next;
            carrier_d_reg <= carrier_sense;
            req_reg <= req_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            hdr_w_reg <= hdr_w_next;
            wdata_reg <= wdata_next;
            txd_reg <= txd_next;
            txe_reg <= tx_active; // [RULE_08]
            rstep_reg <= rstep_next;
            ovr_reg <= ovr_next;
            unr_reg <= unr_next;
        end
    end

    assign bus_request_out      = req_reg;
    assign mem_write            = wr_reg;
    assign mem_read             = rd_reg;
    assign mem_header           = hdr_w_reg;
    assign mem_wdata            = wdata_reg;
    assign tx_data              = txd_reg;
    assign line_transmit_enable = txe_reg;
    assign remote_step          = rstep_reg;
    assign fifo_overrun         = ovr_reg;
    assign fifo_underrun        = unr_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence eof_work_s;
        state_reg inside {dfb_pkg::ST_FLUSH, dfb_pkg::ST_PREP}
        || (state_reg == dfb_pkg::ST_HEADER && hdr_reg != hdr_last);
    endsequence
    sequence hdr_done_s;
        state_reg == dfb_pkg::ST_HEADER && hdr_reg == hdr_last;
    endsequence

    local_first_a: assert property ( // [RULE_01]
        state_reg == dfb_pkg::ST_IDLE && local_need && remote_pending
        |=> state_reg == dfb_pkg::ST_REQ_LOCAL && req_reg)
        else $error("Local need did not win over remote.");
    remote_resume_a: assert property ( // [RULE_02]
        state_reg == dfb_pkg::ST_REQ_REMOTE && bus_grant
        |=> remote_step ##1 !remote_step)
        else $error("Remote step missing after grant.");
    remote_append_a: assert property ( // [RULE_03]
        state_reg == dfb_pkg::ST_REMOTE && local_need
        |=> req_reg && state_reg == dfb_pkg::ST_LOCAL)
        else $error("Local burst not appended to remote tenure.");
    req_gap_a: assert property ( // [RULE_04]
        $rose(state_reg == dfb_pkg::ST_REQ_REMOTE) |-> !$past(req_reg))
        else $error("Remote request without a released request.");
    overrun_flag_a: assert property ( // [RULE_17]
        push && rx_mode_reg && count_reg == dfb_pkg::OVERRUN_LEVEL
        |=> fifo_overrun)
        else $error("Thirteenth byte did not flag overrun.");
    first_req_a: assert property ( // [RULE_10]
        rx_mode_reg && first_reg && first_cnt_reg != '0
        |-> !need_rx)
        else $error("First receive request came too early.");
    first_fill_a: assert property ( // [RULE_11]
        need_rx && first_reg |-> count_reg >= dfb_pkg::FIRST_RX_BYTES)
        else $error("First receive burst below eight bytes.");
    eof_hold_a: assert property ( // [RULE_13]
        eof_work_s |=> req_reg)
        else $error("Request dropped during end of frame.");
    hdr_release_a: assert property ( // [RULE_15]
        hdr_done_s |=> mem_header ##0 !req_reg ##1 !mem_header)
        else $error("Request not released after header.");
    burst_len_a: assert property ( // [RULE_18]
        state_reg == dfb_pkg::ST_LOCAL && bus_grant && burst_last
        && !eof_next |=> !req_reg && state_reg == dfb_pkg::ST_IDLE)
        else $error("Local burst length wrong.");
    txe_hold_a: assert property ( // [RULE_08]
        tx_active && fifo_underrun |=> line_transmit_enable)
        else $error("Transmit enable dropped on underrun.");
    fifo_bound_a: assert property ( // [RULE_05]
        count_reg <= dfb_pkg::FIFO_FULL)
        else $error("FIFO level above its depth.");
endmodule

// >>> common/dfb_pkg.sv
package dfb_pkg;
    localparam int          FIFO_DEPTH     = 16;
    localparam int          PTR_W          = 4;
    localparam int          CNT_W          = 5;
    localparam logic [4:0]  OVERRUN_LEVEL  = 5'h0C;
    localparam logic [4:0]  FIRST_RX_BYTES = 5'h08;
    localparam logic [4:0]  FIFO_FULL      = 5'h10;
    localparam logic [4:0]  BYTE_MODE_ADD  = 5'h01;
    localparam logic [4:0]  WORD_MODE_ADD  = 5'h02;
    localparam logic [2:0]  HDR_BYTES      = 3'h4;
    localparam logic [2:0]  HDR_WORDS      = 3'h2;
    localparam logic [4:0]  THR_2          = 5'h02;
    localparam logic [4:0]  THR_4          = 5'h04;
    localparam logic [4:0]  THR_8          = 5'h08;
    localparam logic [4:0]  THR_12         = 5'h0C;
    localparam int          CLK_PERIOD_PS  = 10000;
    localparam int          FIRST_REQ_PS   = 7800000;
    localparam int          FIRST_REQ_CYC  =
        (FIRST_REQ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          FIRST_CNT_W    = 10;

    typedef enum logic [2:0] {
        ST_IDLE       = 3'b000,
        ST_REQ_LOCAL  = 3'b001,
        ST_LOCAL      = 3'b010,
        ST_FLUSH      = 3'b011,
        ST_PREP       = 3'b100,
        ST_HEADER     = 3'b101,
        ST_REQ_REMOTE = 3'b110,
        ST_REMOTE     = 3'b111
    } dfb_state_type;
endpackage

// >>> common/dfb_fifo_if.sv
`timescale 1ns/1ps
interface dfb_fifo_if #(
    parameter int AW = 4,
    parameter int DW = 8
);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;

    modport ctrl (
        output wr_en,
        output wr_addr,
        output wr_data,
        output rd_addr,
        input  rd_data
    );
    modport store (
        input  wr_en,
        input  wr_addr,
        input  wr_data,
        input  rd_addr,
        output rd_data
    );
endinterface

// >>> logic/dfb_fifo_mem.sv
`timescale 1ns/1ps
module dfb_fifo_mem #(
    parameter int AW = 4,
    parameter int DW = 8
) (
    input  wire logic clk,
    input  wire logic rst_n,
    dfb_fifo_if.store port
);
    logic [DW-1:0] mem_reg [2**AW];
    logic [DW-1:0] rd_data_reg;
    logic [DW-1:0] rd_data_next;

    // The read word is the entry at the read address, one cycle late; reset loads zero instead.
    always_comb begin
        rd_data_next = mem_reg[port.rd_addr];
    end

    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            mem_reg[port.wr_addr] <= port.wr_data;
        end
        if (!rst_n) begin
            rd_data_reg <= '0;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign port.rd_data = rd_data_reg;
endmodule

// >>> testbench/dfb_arbiter_model.sv
`timescale 1ns/1ps
module dfb_arbiter_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       bus_request_out,
    input  wire logic [8:0] latency,
    output logic            bus_grant
);
    logic [8:0] wait_reg;

    initial begin
        bus_grant = 1'b0;
        wait_reg  = 9'h000;
    end

    // Grants after the set wait and takes the grant away once the request
    // falls.
    always @(posedge clk) begin
        #1;
        if (!rst_n || !bus_request_out) begin
            bus_grant <= 1'b0;
            wait_reg  <= 9'h000;
        end else if (wait_reg >= latency) begin
            bus_grant <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 9'h001;
        end
    end
endmodule

// >>> testbench/dfb_dma_sched_tb.sv
`timescale 1ns/1ps
module dfb_dma_sched_tb;
    localparam int FIRST = 20;
    logic       clk, rst_n, word_mode, start_of_frame, carrier_sense;
    logic       rx_valid, tx_active, tx_take, bus_grant, remote_pending;
    logic       bus_request_out, mem_write, mem_read, mem_header;
    logic       line_transmit_enable, remote_step, fifo_overrun;
    logic       fifo_underrun, req_d, take_d, ena_d, cs_d, tx_cmp;
    logic       exp_ovr, eof, rx_on, first_pend;
    logic [1:0] thresh_sel;
    logic [7:0] rx_data, mem_rdata, mem_wdata, tx_data, exp8;
    logic [8:0] lat;
    logic [7:0] rx_q[$], tx_q[$];
    int         mismatches, checked, seed, level, wcnt, hcnt, rsteps, cyc;
    int         rem_cnt, rem_goal, lim;
    int         thr_tab[4] = '{2, 4, 8, 12};

    dfb_dma_sched #(.FIRST_CYC(FIRST)) dfb_dma_sched_inst (
        .clk(clk), .rst_n(rst_n), .word_mode(word_mode),
        .thresh_sel(thresh_sel), .start_of_frame(start_of_frame),
        .carrier_sense(carrier_sense), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_active(tx_active), .tx_take(tx_take),
        .bus_grant(bus_grant), .mem_rdata(mem_rdata),
        .remote_pending(remote_pending), .bus_request_out(bus_request_out),
        .mem_write(mem_write), .mem_read(mem_read), .mem_header(mem_header),
        .mem_wdata(mem_wdata), .tx_data(tx_data),
        .line_transmit_enable(line_transmit_enable),
        .remote_step(remote_step), .fifo_overrun(fifo_overrun),
        .fifo_underrun(fifo_underrun));

    dfb_arbiter_model dfb_arbiter_model_inst (
        .clk(clk), .rst_n(rst_n), .bus_request_out(bus_request_out),
        .latency(lat), .bus_grant(bus_grant));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkc(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cycn(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic note(input string name);
        $display("test %s done at %0t", name, $time);
    endtask

    task automatic do_reset;
        rst_n = 1'b0;
        cycn(20);
        rst_n = 1'b1;
        cycn(1);
    endtask

    task automatic rx_frame(input int n, input int gap, input int tail);
        start_of_frame = 1'b1;
        carrier_sense = 1'b1;
        cycn(1);
        start_of_frame = 1'b0;
        repeat (n) begin
            rx_valid = 1'b1;
            rx_data = $random(seed);
            cycn(1);
            rx_valid = 1'b0;
            cycn(gap);
        end
        cycn(tail);
        carrier_sense = 1'b0;
        for (int i = 0; i < 3000 && rx_on; i++) cycn(1);
        chkc(rx_on, 0);
    endtask

    // Drives the memory read data and the remote demand after each rising edge.
    always @(posedge clk) begin
        #1;
        mem_rdata = $random(seed);
        remote_pending = rem_cnt < rem_goal;
    end

    // Reference model of the FIFO level, byte order and bus tenures.
    always @(posedge clk) begin
        if (!rst_n) begin
            level = 0; eof = 0; rx_on = 0; first_pend = 0; hcnt = 0;
            exp_ovr = 0; rx_q.delete(); tx_q.delete();
        end else begin
            if (start_of_frame) begin
                first_pend = 1; cyc = 0; exp_ovr = 0; rx_on = 1;
            end
            cyc++;
            lim = thr_tab[thresh_sel] + word_mode;
            if (cs_d && !carrier_sense && rx_on) eof = 1;
            if (rx_valid && carrier_sense) begin
                if (level >= 12) exp_ovr = 1;
                level++;
                rx_q.push_back(rx_data);
            end
            if (bus_request_out && !req_d) begin
                if (first_pend && !remote_pending) begin
                    chkc(cyc >= FIRST, 1);
                    chkc(level >= 8, 1);
                    first_pend = 0;
                end else if (rx_on && !eof && !remote_pending && !first_pend)
                    chkc(level > lim, 1);
                wcnt = 0;
                rsteps = 0;
            end
            if (mem_write && !mem_header) begin
                exp8 = rx_q.size() ? rx_q.pop_front() : 8'hXX;
                chk8(mem_wdata, exp8);
                level--; wcnt++; first_pend = 0;
            end
            if (mem_write && mem_header) begin
                chk8(mem_wdata, {6'h00, exp_ovr, 1'b1});
                chkc(rx_q.size(), 0);
                hcnt++;
            end
            if (remote_step) begin
                chkc(wcnt, 0);
                rsteps++; rem_cnt++;
                chkc(rsteps, 1);
            end
            if (!bus_request_out && req_d) begin
                if (eof && hcnt > 0) begin
                    chkc(hcnt, word_mode ? 2 : 4);
                    chkc(fifo_overrun, exp_ovr);
                    eof = 0; rx_on = 0; hcnt = 0;
                end else if (wcnt > 0)
                    chkc(wcnt, thr_tab[thresh_sel]);
            end
            if (mem_read) tx_q.push_back(mem_rdata);
            if (take_d && tx_cmp) begin
                exp8 = tx_q.size() ? tx_q.pop_front() : 8'hXX;
                chk8(tx_data, exp8);
            end
            chkc(line_transmit_enable, ena_d);
        end
        req_d = bus_request_out; take_d = tx_take;
        ena_d = tx_active; cs_d = carrier_sense;
    end

    initial begin
        #(40000 * 10);
        mismatches++;
        $display("watchdog expired at %0t", $time);
        end_of_test();
    end

    initial begin
        rst_n = 1'b0; word_mode = 1'b0; thresh_sel = 2'b00; rx_valid = 1'b0;
        start_of_frame = 1'b0; carrier_sense = 1'b0; rx_data = 8'h00;
        tx_active = 1'b0; tx_take = 1'b0; mem_rdata = 8'h00; lat = 9'h001;
        remote_pending = 1'b0; seed = 32'h27a3; tx_cmp = 1'b1;
        #1;
        do_reset();
        rx_frame(9, 1, 30);
        note("first request");
        for (int m = 0; m < 2; m++) begin
            for (int s = 0; s < 4; s++) begin
                word_mode = m[0];
                thresh_sel = s[1:0];
                lat = {7'h00, 2'($random(seed))};
                rx_frame(30, 5, 4);
            end
        end
        note("thresholds");
        word_mode = 1'b0; thresh_sel = 2'b10; lat = 9'h03C;
        rx_frame(13, 1, 80);
        note("overrun");
        thresh_sel = 2'b01; lat = 9'h002; rem_goal = rem_cnt + 40;
        cycn(10);
        rx_frame(30, 5, 4);
        for (int i = 0; i < 1000 && rem_cnt < rem_goal; i++) cycn(1);
        chkc(rem_cnt, rem_goal);
        note("remote interleave");
        tx_active = 1'b1;
        cycn(40);
        repeat (24) begin
            tx_take = 1'b1;
            cycn(1);
            tx_take = 1'b0;
            cycn(6);
        end
        chkc(fifo_underrun, 0);
        tx_active = 1'b0;
        cycn(5);
        note("transmit");
        do_reset();
        lat = 9'h12C; tx_cmp = 1'b0; tx_active = 1'b1;
        cycn(2);
        repeat (3) begin
            tx_take = 1'b1;
            cycn(1);
            tx_take = 1'b0;
            cycn(2);
        end
        chkc(fifo_underrun, 1);
        chkc(line_transmit_enable, 1);
        note("underrun");
        end_of_test();
    end
endmodule
